// ==== design/asimd_pkg.sv ====
// Constants, register map and types of the slave-diagnostics block
package asimd_pkg;
	// --------
	// Clock and timing
	// --------
	localparam int unsigned CLK_FREQ_HZ = 125_000_000;
	localparam real SET_HOLD_S = 0.5;
	localparam int unsigned SET_HOLD_CYC = int'($ceil(SET_HOLD_S * CLK_FREQ_HZ));
	localparam real FLASH_HALF_S = 0.25;
	localparam int unsigned FLASH_HALF_CYC = int'($floor(FLASH_HALF_S * CLK_FREQ_HZ));

	// --------
	// Widths
	// --------
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam int NUM_SLAVES = 64;
	localparam int SLV_IDX_W = 6;

	// --------
	// Register byte offsets
	// --------
	localparam logic [AXI_ADDR_W-1:0] REC_W0_OFS = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] REC_W1_OFS = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] REC_W2_OFS = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] REC_W3_OFS = 8'h0c;
	localparam logic [AXI_ADDR_W-1:0] CTRL_OFS = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] EVENT_OFS = 8'h14;
	localparam logic [AXI_ADDR_W-1:0] STATUS_OFS = 8'h18;
	localparam logic [AXI_ADDR_W-1:0] CFG_LO_OFS = 8'h1c;
	localparam logic [AXI_ADDR_W-1:0] CFG_HI_OFS = 8'h20;

	// --------
	// Field positions and reset values
	// --------
	localparam int CTRL_AUTO_EN_BIT = 0;
	localparam logic CTRL_AUTO_EN_RST = 1'b1;
	localparam int EVT_CHANGE_BIT = 0;
	localparam int EVT_ENTER_BIT = 1;
	localparam int ST_PROT_BIT = 0;
	localparam int ST_CONF_BIT = 1;
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_ADDR0_BIT = 3;
	localparam int ST_FIDX_LSB = 4;
	localparam int B_SLAVE_BASE = 32;

	// --------
	// Fixed record bytes; address 0 of both halves is never a station
	// --------
	localparam logic [7:0] REC_B1_CLASS = 8'h1c;
	localparam logic [7:0] REC_B4_FIX = 8'h60;
	localparam logic [7:0] REC_B5_FIX = 8'h00;
	localparam logic [7:0] REC_B6_FIX = 8'h40;
	localparam logic [7:0] REC_B15_RSV = 8'h00;
	localparam logic [NUM_SLAVES-1:0] SLAVE_MASK = 64'hffff_fffe_ffff_fffe;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// --------
	// Auto-addressing states
	// --------
	typedef enum logic [3:0] {
		AP_IDLE = 4'b0001,
		AP_PROG = 4'b0010,
		AP_WAIT = 4'b0100,
		AP_DONE = 4'b1000
	} asimd_ap_state_e;
endpackage

// ==== design/asimd_hold_timer.sv ====
// Hold timer: one pulse after an input has stood high long enough
`timescale 1ns/10ps
module asimd_hold_timer #(
	parameter int unsigned CYCLES = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic run,
	output logic expired
);
	import asimd_pkg::*;

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic fired_q;
	logic hit;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// One pulse per press; re-arms only after the input drops
	assign hit = run && !fired_q && (cnt_q == CYCLES - 32'd1);
	assign cnt_d = (!run || fired_q) ? 32'd0 : cnt_q + 32'd1;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'd0;
			fired_q <= 1'b0;
			expired <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			fired_q <= run && (fired_q || hit);
			expired <= hit;
		end
	end
endmodule

// ==== design/asimd_core.sv ====
// Slave diagnostics, delta list, indicators and automatic addressing
//
// Notes on behaviour
// [R01] Missing configured slave in protected mode sets its delta bit, raises event.
// [R02] Unconfigured slave appearing sets its delta bit and raises another event.
// [R03] Returning slave clears only its own bit; remaining bits keep fault state.
// [R04] Last discrepancy gone raises event flagged leaving, delta list all zero.
// [R05] Auto addressing only in protected mode with exactly one missing slave.
// [R06] No auto addressing for multiaddress CTT5 slaves.
// [R07] Auto-program-ready lit only protected, exactly one failed, addressing possible.
// [R08] Indicator of a failed slave flashes.
// [R09] Identical slave at address 0 is reprogrammed to the failed address.
// [R10] After success ready indicator off, slave indicator shows included.
// [R11] Power-fail indicator lit while cable voltage is too low.
// [R12] Group fault lit in protected mode while a configuration error exists.
// [R13] Defective configuration memory lights group fault and logs internal fault.
// [R14] Address-0 slave at protected-mode request lights group fault.
// [R15] Config error indicator lit while no configuration has been stored.
// [R16] Config error lit for missing configured or present unconfigured slave.
// [R17] I/O configuration or ID mismatch counts as error, lights config error.
// [R18] SET button captures the present slaves as expected configuration.
// [R19] Delta list kept continuously, one bit per slave, 1 means error.
// [R20] Bit 0 of each delta byte is lowest slave number, ascending upward.
// [R21] Diagnostic record is 16 bytes holding standard and B delta lists.
// [R22] Operator holds SET at least 0.5 s with host stopped to change mode.
// [R23] Every delta change raises event, entering if any bit, else leaving.
// [R24] Mode bit selects protected or configuration; configuration blocks auto addressing.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module asimd_core #(
	parameter int unsigned SET_HOLD_CYCLES = asimd_pkg::SET_HOLD_CYC,
	parameter int unsigned FLASH_HALF_CYCLES = asimd_pkg::FLASH_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [asimd_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [asimd_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [asimd_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [asimd_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [asimd_pkg::NUM_SLAVES-1:0] present_list,
	input wire logic [asimd_pkg::NUM_SLAVES-1:0] mismatch_list,
	input wire logic [asimd_pkg::NUM_SLAVES-1:0] ctt5_list,
	input wire logic addr0_present,
	input wire logic addr0_identical,
	input wire logic power_low,
	input wire logic nvm_defect,
	input wire logic set_button,
	input wire logic host_stopped,
	input wire logic prog_done,
	input wire logic prog_fail,
	output logic prog_req,
	output logic [asimd_pkg::SLV_IDX_W-1:0] prog_addr,
	output logic diag_irq,
	output logic diag_entering,
	output logic protected_mode,
	output logic auto_program_ready_indicator,
	output logic power_fail_indicator,
	output logic group_fault_indicator,
	output logic config_error_indicator,
	output logic [asimd_pkg::NUM_SLAVES-1:0] slave_indicator
);
	import asimd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [NUM_SLAVES-1:0] cfg_q;
	logic configured_q;
	logic int_fault_q;
	logic addr0_block_q;
	logic [NUM_SLAVES-1:0] delta_q;
	logic auto_en_q;
	logic evt_change_q;
	logic evt_enter_q;
	logic [31:0] flash_cnt_q;
	logic flash_q;
	asimd_ap_state_e ap_q;
	asimd_ap_state_e ap_d;
	logic set_long;

	// ----------------------------------------------------------------
	// Delta list
	// ----------------------------------------------------------------
	logic [NUM_SLAVES-1:0] present_m;
	logic [NUM_SLAVES-1:0] missing_w;
	logic [NUM_SLAVES-1:0] extra_w;
	logic [NUM_SLAVES-1:0] wrong_w;
	logic [NUM_SLAVES-1:0] delta_w;
	logic delta_nz;
	logic delta_chg;

	assign present_m = present_list & SLAVE_MASK;
	assign missing_w = cfg_q & ~present_m; // [R01]
	assign extra_w = present_m & ~cfg_q; // [R02]
	assign wrong_w = cfg_q & present_m & mismatch_list & SLAVE_MASK; // [R17]
	// Recomputed every cycle, so a returning slave clears only its own bit
	assign delta_w = missing_w | extra_w | wrong_w; // [R19] [R03]
	assign delta_nz = |delta_q;
	assign delta_chg = delta_w != delta_q; // [R23]

	// ----------------------------------------------------------------
	// Automatic addressing qualification
	// ----------------------------------------------------------------
	function automatic logic [SLV_IDX_W-1:0] first_set(input logic [NUM_SLAVES-1:0] v);
		logic [SLV_IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SLAVES - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = SLV_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	logic single_missing;
	logic ctt5_hit;
	logic ap_possible;
	logic [SLV_IDX_W-1:0] fail_idx;

	assign single_missing = (missing_w != '0) &&
		((missing_w & (missing_w - 64'h1)) == '0); // [R05]
	assign ctt5_hit = |(missing_w & ctt5_list); // [R06]
	// Extra unconfigured stations make the replacement ambiguous
	assign ap_possible = protected_mode && auto_en_q && single_missing &&
		!ctt5_hit && (extra_w == '0); // [R05] [R24]
	assign fail_idx = first_set(missing_w);

	always_comb begin
		ap_d = ap_q;
		case (ap_q)
			AP_IDLE: begin
				if (ap_possible && addr0_present && addr0_identical) begin
					ap_d = AP_PROG; // [R09]
				end
			end
			AP_PROG: begin
				ap_d = AP_WAIT;
			end
			AP_WAIT: begin
				if (prog_done) begin
					ap_d = AP_DONE;
				end else if (prog_fail) begin
					ap_d = AP_IDLE;
				end
			end
			AP_DONE: begin
				// Wait for the station to show up under its new address
				if (!single_missing) begin
					ap_d = AP_IDLE;
				end
			end
			default: begin
				ap_d = AP_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// SET button and mode
	// ----------------------------------------------------------------
	asimd_hold_timer #(
		.CYCLES(SET_HOLD_CYCLES)
	) u_set_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(set_button && host_stopped), // [R22]
		.expired(set_long)
	);

	logic to_prot;
	logic to_prot_refused;
	logic to_conf;

	assign to_prot = set_long && !protected_mode && !addr0_present; // [R18]
	assign to_prot_refused = set_long && !protected_mode && addr0_present; // [R14]
	assign to_conf = set_long && protected_mode; // [R24]

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			protected_mode <= 1'b0;
			configured_q <= 1'b0;
			cfg_q <= '0;
		end else begin
			if (to_prot) begin
				cfg_q <= present_m; // [R18]
				configured_q <= 1'b1;
				protected_mode <= 1'b1;
			end else if (to_conf) begin
				protected_mode <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr0_block_q <= 1'b0;
			int_fault_q <= 1'b0;
		end else begin
			addr0_block_q <= to_prot_refused || (addr0_block_q && addr0_present); // [R14]
			int_fault_q <= int_fault_q || nvm_defect; // [R13]
		end
	end

	// ----------------------------------------------------------------
	// Delta register, diagnostic event, programming request
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			delta_q <= '0;
			diag_irq <= 1'b0;
			diag_entering <= 1'b0;
			ap_q <= AP_IDLE;
			prog_req <= 1'b0;
			prog_addr <= '0;
		end else begin
			delta_q <= delta_w; // [R19]
			diag_irq <= delta_chg; // [R01] [R02] [R03] [R04] [R23]
			if (delta_chg) begin
				diag_entering <= |delta_w; // [R03] [R04]
			end
			ap_q <= ap_d;
			prog_req <= (ap_q == AP_IDLE) && (ap_d == AP_PROG); // [R09]
			if ((ap_q == AP_IDLE) && (ap_d == AP_PROG)) begin
				prog_addr <= fail_idx; // [R09]
			end
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	logic flash_wrap;

	assign flash_wrap = flash_cnt_q == FLASH_HALF_CYCLES - 32'd1;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt_q <= 32'd0;
			flash_q <= 1'b0;
		end else begin
			flash_cnt_q <= flash_wrap ? 32'd0 : flash_cnt_q + 32'd1;
			flash_q <= flash_q ^ flash_wrap;
		end
	end

	logic [NUM_SLAVES-1:0] slave_ind_d;

	for (genvar i = 0; i < NUM_SLAVES; i++) begin : g_slave_ind
		// Missing stations flash, present ones show steady
		assign slave_ind_d[i] = missing_w[i] ? flash_q : present_m[i]; // [R08] [R10]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_program_ready_indicator <= 1'b0;
			power_fail_indicator <= 1'b0;
			group_fault_indicator <= 1'b0;
			config_error_indicator <= 1'b0;
			slave_indicator <= '0;
		end else begin
			// Kept dark while a reprogramming is under way
			auto_program_ready_indicator <= ap_possible && (ap_q == AP_IDLE); // [R07] [R10]
			power_fail_indicator <= power_low; // [R11]
			group_fault_indicator <= (protected_mode && (delta_w != '0)) ||
				int_fault_q || nvm_defect || addr0_block_q || to_prot_refused; // [R12] [R13] [R14]
			config_error_indicator <= !configured_q || (delta_w != '0); // [R15] [R16] [R17]
			slave_indicator <= slave_ind_d; // [R08]
		end
	end

	// ----------------------------------------------------------------
	// Diagnostic record
	// ----------------------------------------------------------------
	logic ext_fault;
	logic group_err;
	logic [7:0] rec_b0;
	logic [7:0] rec_b2;
	logic [7:0] rec_b3;
	logic [31:0] rec_w0;
	logic [31:0] rec_w1;
	logic [31:0] rec_w2;
	logic [31:0] rec_w3;

	assign ext_fault = delta_nz || power_low;
	assign group_err = ext_fault || int_fault_q;
	assign rec_b0 = {3'b000, power_low, delta_nz, ext_fault, int_fault_q, group_err};
	assign rec_b2 = {7'b0000000, delta_nz};
	assign rec_b3 = {5'b00000, int_fault_q, 2'b00}; // [R13]
	// Little-endian: record byte n sits in lane n mod 4 of word n div 4
	assign rec_w0 = {rec_b3, rec_b2, REC_B1_CLASS, rec_b0}; // [R21]
	assign rec_w1 = {delta_q[7:0], REC_B6_FIX, REC_B5_FIX, REC_B4_FIX}; // [R20] [R21]
	assign rec_w2 = delta_q[39:8]; // [R20]
	assign rec_w3 = {REC_B15_RSV, delta_q[63:40]}; // [R20] [R21]

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic aw_held_q;
	logic [AXI_DATA_W-1:0] wdata_q;
	logic [3:0] wstrb_q;
	logic w_held_q;
	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic wr_ctrl;
	logic wr_event;
	logic wr_ok;
	logic evt_clear;

	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && (awaddr_q == CTRL_OFS) && wstrb_q[0];
	assign wr_event = wr_fire && (awaddr_q == EVENT_OFS) && wstrb_q[0];
	assign wr_ok = (awaddr_q == CTRL_OFS) || (awaddr_q == EVENT_OFS);
	assign evt_clear = wr_event && wdata_q[EVT_CHANGE_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_held_q <= (aw_held_q && !wr_fire) || aw_take;
			w_held_q <= (w_held_q && !wr_fire) || w_take;
			s_axi_awready <= !(aw_held_q && !wr_fire) && !aw_take;
			s_axi_wready <= !(w_held_q && !wr_fire) && !w_take;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_en_q <= CTRL_AUTO_EN_RST;
			evt_change_q <= 1'b0;
			evt_enter_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				auto_en_q <= wdata_q[CTRL_AUTO_EN_BIT];
			end
			// A new change in the clearing cycle wins over the clear
			evt_change_q <= delta_chg || (evt_change_q && !evt_clear); // [R23]
			if (delta_chg) begin
				evt_enter_q <= |delta_w;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic ar_take;
	logic [31:0] ctrl_rd;
	logic [31:0] evt_rd;
	logic [31:0] status_rd;
	logic [31:0] rd_mux;
	logic rd_hit;

	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign ctrl_rd = {31'd0, auto_en_q};
	assign evt_rd = {30'd0, evt_enter_q, evt_change_q};
	assign status_rd = {22'd0, fail_idx, addr0_block_q, (ap_q != AP_IDLE),
		configured_q, protected_mode};
	assign rd_hit = (s_axi_araddr <= CFG_HI_OFS) && (s_axi_araddr[1:0] == 2'b00);
	assign rd_mux = (s_axi_araddr == REC_W0_OFS) ? rec_w0 :
		(s_axi_araddr == REC_W1_OFS) ? rec_w1 :
		(s_axi_araddr == REC_W2_OFS) ? rec_w2 :
		(s_axi_araddr == REC_W3_OFS) ? rec_w3 :
		(s_axi_araddr == CTRL_OFS) ? ctrl_rd :
		(s_axi_araddr == EVENT_OFS) ? evt_rd :
		(s_axi_araddr == STATUS_OFS) ? status_rd :
		(s_axi_araddr == CFG_LO_OFS) ? cfg_q[31:0] :
		(s_axi_araddr == CFG_HI_OFS) ? cfg_q[63:32] : 32'd0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ==== tb/asimd_core_assertions.sv ====
// Checker of the slave-diagnostics block ports
`timescale 1ns/10ps
module asimd_core_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [asimd_pkg::NUM_SLAVES-1:0] present_list,
	input wire logic [asimd_pkg::NUM_SLAVES-1:0] ctt5_list,
	input wire logic addr0_present,
	input wire logic addr0_identical,
	input wire logic power_low,
	input wire logic nvm_defect,
	input wire logic set_button,
	input wire logic host_stopped,
	input wire logic prog_req,
	input wire logic [asimd_pkg::SLV_IDX_W-1:0] prog_addr,
	input wire logic diag_irq,
	input wire logic diag_entering,
	input wire logic protected_mode,
	input wire logic auto_program_ready_indicator,
	input wire logic power_fail_indicator,
	input wire logic group_fault_indicator,
	input wire logic config_error_indicator
);
	import asimd_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// --------
	// Indicators
	// --------
	a_power_fail: assert property ($rose(power_low) |=> power_fail_indicator)
		else $error("power fail dark");
	a_nvm_group: assert property (nvm_defect |=> group_fault_indicator)
		else $error("no fault on memory defect");
	a_enter_group: assert property (diag_irq && diag_entering && protected_mode
		|-> group_fault_indicator) else $error("no fault on entry");
	a_enter_cfg: assert property (diag_irq && diag_entering |-> config_error_indicator)
		else $error("no config error on entry");
	a_leave_clean: assert property (diag_irq && !diag_entering && protected_mode
		|-> !config_error_indicator) else $error("config error after leaving");
	// The indicator settles one edge after the mode flag
	a_ready_mode: assert property (!protected_mode
		|=> !auto_program_ready_indicator) else $error("ready lit in configuration");
	// --------
	// Automatic addressing and mode
	// --------
	a_prog_cause: assert property (prog_req
		|-> $past(addr0_present && addr0_identical && protected_mode))
		else $error("unqualified programming");
	a_prog_target: assert property (prog_req
		|-> (($past(present_list) >> prog_addr) & 64'h1) == 64'h0)
		else $error("target was present");
	a_prog_ctt5: assert property (prog_req
		|-> (($past(ctt5_list) >> prog_addr) & 64'h1) == 64'h0)
		else $error("multiaddress target");
	a_mode_hold: assert property ($changed(protected_mode)
		|-> $past(set_button, 2) && $past(host_stopped, 2)) else $error("mode changed unheld");
endmodule

bind asimd_core asimd_core_chk asimd_core_chk_inst (.core_clk, .rst_n, .present_list, .ctt5_list,
	.addr0_present, .addr0_identical, .power_low, .nvm_defect, .set_button, .host_stopped,
	.prog_req, .prog_addr, .diag_irq, .diag_entering, .protected_mode,
	.auto_program_ready_indicator, .power_fail_indicator, .group_fault_indicator,
	.config_error_indicator);

// ==== tb/asimd_slave_model.sv ====
// Behavioural model of the slaves on the cable
`timescale 1ns/10ps
module asimd_slave_model #(
	parameter int DELAY = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [asimd_pkg::NUM_SLAVES-1:0] plugged,
	input wire logic spare0,
	input wire logic prog_req,
	input wire logic [asimd_pkg::SLV_IDX_W-1:0] prog_addr,
	output logic [asimd_pkg::NUM_SLAVES-1:0] present_list,
	output logic addr0_present,
	output logic addr0_identical,
	output logic prog_done,
	output logic prog_fail
);
	import asimd_pkg::*;
	logic [NUM_SLAVES-1:0] moved_q;
	logic used_q;
	int cnt_q;
	assign present_list = plugged | moved_q;
	assign addr0_present = spare0 && !used_q;
	assign addr0_identical = addr0_present;
	// No scenario asks for a failed readdressing
	assign prog_fail = 1'b0;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			moved_q <= '0;
			used_q <= 1'b0;
			cnt_q <= 0;
			prog_done <= 1'b0;
		end else begin
			prog_done <= (cnt_q == 1);
			if (prog_req)
				cnt_q <= DELAY;
			else if (cnt_q != 0)
				cnt_q <= cnt_q - 1;
			if (cnt_q == 1) begin
				moved_q <= moved_q | (64'h1 << prog_addr);
				used_q <= 1'b1;
			end
			if (!spare0)
				used_q <= 1'b0;
		end
	end
endmodule

// ==== tb/test_asi_master_diagnostics.sv ====
// Self-checking bench of the slave-diagnostics block
`timescale 1ns/10ps
module test_asi_master_diagnostics;
	import asimd_pkg::*;
	localparam int HOLD = 20;
	logic core_clk = 0;
	logic rst_n = 0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [63:0] plugged = '0, mismatch_list = '0, ctt5_list = '0, present_list, slave_indicator;
	logic spare0 = 0, power_low = 0, nvm_defect = 0, set_button = 0, host_stopped = 0;
	logic addr0_present, addr0_identical, prog_done, prog_fail, prog_req, diag_irq;
	logic diag_entering, protected_mode, auto_program_ready_indicator;
	logic power_fail_indicator, group_fault_indicator, config_error_indicator;
	logic [5:0] prog_addr;
	int mismatches = 0;
	int n_checks = 0;
	always #4 core_clk = ~core_clk;
	asimd_core #(.SET_HOLD_CYCLES(HOLD), .FLASH_HALF_CYCLES(4)) asimd_core_inst (.core_clk,
		.rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.present_list, .mismatch_list, .ctt5_list, .addr0_present, .addr0_identical, .power_low,
		.nvm_defect, .set_button, .host_stopped, .prog_done, .prog_fail, .prog_req, .prog_addr,
		.diag_irq, .diag_entering, .protected_mode, .auto_program_ready_indicator,
		.power_fail_indicator, .group_fault_indicator, .config_error_indicator, .slave_indicator);
	asimd_slave_model asimd_slave_model_inst (.core_clk, .rst_n, .plugged, .spare0, .prog_req,
		.prog_addr, .present_list, .addr0_present, .addr0_identical, .prog_done, .prog_fail);
	// --------
	// Shared tasks
	// --------
	task wrap_up;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task guard(input int n);
		if (n > 200) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// Sample 1 ns past the edge
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge core_clk);
			guard(++n);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge core_clk);
			guard(++n);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(r, RESP_OKAY);
		chk(d, exp);
	endtask
	task plug(input logic [63:0] p, input logic ent);
		plugged <= p;
		step(1);
		chk(diag_irq, 1);
		chk(diag_entering, ent);
	endtask
	// Button held past hold time, host stopped
	task press_set;
		set_button <= 1;
		host_stopped <= 1;
		step(HOLD + 4);
		set_button <= 0;
		host_stopped <= 0;
		step(3);
	endtask
	task automatic flash(input int i);
		logic on = 0, off = 0;
		repeat (12) begin
			step(1);
			on |= slave_indicator[i];
			off |= !slave_indicator[i];
		end
		chk({on, off}, 2'b11);
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk(config_error_indicator, 1);
		rd_chk(CTRL_OFS, 32'h1);
		rd_chk(REC_W1_OFS, 32'h00400060);
		axi_wr(8'h24, 32'h0, r);
		chk(r, RESP_SLVERR);
		axi_rd(8'h24, d, r);
		chk(r, RESP_SLVERR);
	endtask
	task t_config;
		plugged <= 64'h1082;
		press_set();
		chk(protected_mode, 1);
		rd_chk(CFG_LO_OFS, 32'h1082);
		rd_chk(STATUS_OFS, 32'h3);
		chk(config_error_indicator, 0);
	endtask
	task t_deltas;
		plug(64'h1002, 1);
		chk({group_fault_indicator, config_error_indicator}, 2'b11);
		chk(auto_program_ready_indicator, 1);
		rd_chk(REC_W0_OFS, 32'h00011c0d);
		rd_chk(REC_W1_OFS, 32'h80400060);
		flash(7);
		plug(64'h9002, 1);
		rd_chk(REC_W2_OFS, 32'h00000080);
		chk(config_error_indicator, 1);
		plug(64'h9082, 1);
		rd_chk(REC_W1_OFS, 32'h00400060);
		rd_chk(REC_W2_OFS, 32'h00000080);
		plug(64'h1082, 0);
		rd_chk(REC_W0_OFS, 32'h00001c00);
		rd_chk(REC_W2_OFS, 32'h0);
		chk(group_fault_indicator, 0);
	endtask
	task automatic t_auto;
		int n = 0;
		plug(64'h1002, 1);
		chk(auto_program_ready_indicator, 1);
		spare0 <= 1;
		do begin
			step(1);
			guard(++n);
		end while (prog_req !== 1'b1);
		chk(prog_addr, 6'd7);
		step(8);
		chk(auto_program_ready_indicator, 0);
		chk(slave_indicator[7], 1);
		rd_chk(REC_W1_OFS, 32'h00400060);
		spare0 <= 0;
	endtask
	task automatic t_misc;
		logic [1:0] r;
		ctt5_list[12] <= 1;
		plug(64'h0002, 1);
		chk(auto_program_ready_indicator, 0);
		plug(64'h1002, 0);
		ctt5_list[12] <= 0;
		mismatch_list[1] <= 1;
		step(2);
		chk(config_error_indicator, 1);
		mismatch_list[1] <= 0;
		power_low <= 1;
		step(2);
		chk(power_fail_indicator, 1);
		power_low <= 0;
		step(3);
		rd_chk(EVENT_OFS, 32'h1);
		axi_wr(EVENT_OFS, 32'h1, r);
		rd_chk(EVENT_OFS, 32'h0);
	endtask
	task t_mode;
		press_set();
		chk(protected_mode, 0);
		plug(64'h0002, 1);
		chk(auto_program_ready_indicator, 0);
		plug(64'h1002, 0);
		spare0 <= 1;
		step(2);
		press_set();
		chk({protected_mode, group_fault_indicator}, 2'b01);
		spare0 <= 0;
		nvm_defect <= 1;
		step(2);
		chk(group_fault_indicator, 1);
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1;
		step(2);
		t_reset();
		t_config();
		t_deltas();
		t_auto();
		t_misc();
		t_mode();
		wrap_up();
	end
endmodule
